//--- hw/ccs_consts.svh
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

// ----------------------------------------------------------------------------
// configuration pin codes, first printed bit is bit 3
// ----------------------------------------------------------------------------
`define CCS_CFG_X2_0      4'h4
`define CCS_CFG_X2_5      4'h6
`define CCS_CFG_X3_0      4'h8
`define CCS_CFG_X3_5      4'he
`define CCS_CFG_X4_0      4'ha
`define CCS_CFG_X4_5      4'h7
`define CCS_CFG_X5_0      4'hb
`define CCS_CFG_X5_5      4'h9
`define CCS_CFG_X6_0      4'hd
`define CCS_CFG_X6_5      4'h5
`define CCS_CFG_X7_0      4'h2
`define CCS_CFG_X7_5      4'h1
`define CCS_CFG_X8_0      4'hc
`define CCS_CFG_X9_0      4'h0
`define CCS_CFG_BYPASS    4'h3
`define CCS_CFG_OFF       4'hf

// ----------------------------------------------------------------------------
// bus-to-core multiplier in half steps (2x -> 4)
// ----------------------------------------------------------------------------
`define CCS_M2_X2_0       5'h04
`define CCS_M2_X2_5       5'h05
`define CCS_M2_X3_0       5'h06
`define CCS_M2_X3_5       5'h07
`define CCS_M2_X4_0       5'h08
`define CCS_M2_X4_5       5'h09
`define CCS_M2_X5_0       5'h0a
`define CCS_M2_X5_5       5'h0b
`define CCS_M2_X6_0       5'h0c
`define CCS_M2_X6_5       5'h0d
`define CCS_M2_X7_0       5'h0e
`define CCS_M2_X7_5       5'h0f
`define CCS_M2_X8_0       5'h10
`define CCS_M2_X9_0       5'h12
`define CCS_M2_NONE       5'h00

// ----------------------------------------------------------------------------
// cache clock divisor field: 0 stops, k gives divide by (k+1)/2
// ----------------------------------------------------------------------------
`define CCS_DIV_OFF       3'h0
`define CCS_DIV_HI_BIAS   4'h2

// ----------------------------------------------------------------------------
// delay-locked loop and reference period counter defaults
// ----------------------------------------------------------------------------
`define CCS_DLL_TAPS      64
`define CCS_DLL_TAP_W     6
`define CCS_PERIOD_W      16

`endif

//--- hw/ccs_pkg.sv
package ccs_pkg;

    // ------------------------------------------------------------------------
    // core clock source modes
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ccs_mode_pll,
        ccs_mode_bypass,
        ccs_mode_off
    } ccs_mode_t;

endpackage

//--- hw/ccs_cache_div.sv
`timescale 1ns/1ps
`include "ccs_consts.svh"

module ccs_cache_div #(
    parameter int DIV_W = 3
) (
    input  wire logic             clk_sys,     // system clock
    input  wire logic             rst_n,       // async reset, active low
    input  wire logic             phase_tick,  // one pulse per core half period
    input  wire logic [DIV_W-1:0] divisor,     // cache clock divisor field
    output logic                  cache_clk    // divided cache clock level
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    logic [DIV_W:0]   cnt_q, cnt_d;     // half periods into current cycle
    logic [DIV_W-1:0] div_q, div_d;     // divisor in use
    logic             clk_q, clk_d;     // output level

    // high time in half periods, larger half for odd totals
    function automatic logic [DIV_W:0] ccs_hi_len(input logic [DIV_W-1:0] k);
        ccs_hi_len = (DIV_W+1)'(({1'b0, k} + `CCS_DIV_HI_BIAS) >> 1);
    endfunction

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    // a new divisor is taken only at a period boundary or while stopped, so no runt appears
    always_comb begin
        cnt_d = cnt_q;
        div_d = div_q;
        clk_d = clk_q;
        if (div_q == `CCS_DIV_OFF) begin                // stopped: load at once
            cnt_d = '0;
            div_d = divisor;
            clk_d = 1'b0;
        end else if (phase_tick) begin
            if (cnt_q == {1'b0, div_q}) begin           // last half period
                cnt_d = '0;
                div_d = divisor;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
            // period is k+1 half periods of the core clock
            clk_d = (div_d != `CCS_DIV_OFF) && (cnt_d < ccs_hi_len(div_d));
        end
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            div_q <= `CCS_DIV_OFF;
            clk_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            div_q <= div_d;
            clk_q <= clk_d;
        end
    end

    assign cache_clk = clk_q;

endmodule // ccs_cache_div

//--- hw/ccs_clock_select.sv
`timescale 1ns/1ps
`include "ccs_consts.svh"

module ccs_clock_select #(
    parameter int PERIOD_W = `CCS_PERIOD_W,   // reference period counter width
    parameter int DLL_TAPS = `CCS_DLL_TAPS,   // delay line length in clk_sys cycles
    parameter int TAP_W    = `CCS_DLL_TAP_W   // tap select width
) (
    input  wire logic       clk_sys,                  // 50 MHz system clock
    input  wire logic       rst_n,                    // async reset, active low
    input  wire logic       bus_reference_clock,      // bus reference, sampled
    input  wire logic [3:0] pll_cfg,                  // static configuration pins
    input  wire logic [2:0] cache_clk_divisor,        // divisor field
    input  wire logic       cache_low_speed_bit,      // low-speed setting
    input  wire logic       cache_clk_feedback_in,    // returned sync clock
    output logic            core_clk,                 // core clock level
    output logic            core_tick,                // pulse at core rising edge
    output logic            vco_tick,                 // pulse per oscillator period
    output logic            pll_active,               // multiplier mode in use
    output logic            bypass_active,            // reference drives core
    output logic            clocks_off,               // nothing is clocked
    output logic            cache_clk_out,            // aligned cache clock
    output logic            cache_clk_feedback_out,   // separate sync clock copy
    output logic            dll_locked,               // delay loop has settled
    output logic            cache_low_speed           // registered low-speed setting
);

    // ------------------------------------------------------------------------
    // pin decode
    // ------------------------------------------------------------------------
    // half-step multiplier, zero for the two non-multiplying codes
    function automatic logic [4:0] ccs_mult2(input logic [3:0] cfg);
        case (cfg)
            `CCS_CFG_X2_0: ccs_mult2 = `CCS_M2_X2_0;
            `CCS_CFG_X2_5: ccs_mult2 = `CCS_M2_X2_5;
            `CCS_CFG_X3_0: ccs_mult2 = `CCS_M2_X3_0;
            `CCS_CFG_X3_5: ccs_mult2 = `CCS_M2_X3_5;
            `CCS_CFG_X4_0: ccs_mult2 = `CCS_M2_X4_0;
            `CCS_CFG_X4_5: ccs_mult2 = `CCS_M2_X4_5;
            `CCS_CFG_X5_0: ccs_mult2 = `CCS_M2_X5_0;
            `CCS_CFG_X5_5: ccs_mult2 = `CCS_M2_X5_5;
            `CCS_CFG_X6_0: ccs_mult2 = `CCS_M2_X6_0;
            `CCS_CFG_X6_5: ccs_mult2 = `CCS_M2_X6_5;
            `CCS_CFG_X7_0: ccs_mult2 = `CCS_M2_X7_0;
            `CCS_CFG_X7_5: ccs_mult2 = `CCS_M2_X7_5;
            `CCS_CFG_X8_0: ccs_mult2 = `CCS_M2_X8_0;
            `CCS_CFG_X9_0: ccs_mult2 = `CCS_M2_X9_0;
            default:       ccs_mult2 = `CCS_M2_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // mode and reference state
    // ------------------------------------------------------------------------
    ccs_pkg::ccs_mode_t  mode_q, mode_d;       // selected clock source
    logic [4:0]          m2_q, m2_d;           // multiplier in half steps
    logic                bus_q;                // reference delayed one cycle
    logic [PERIOD_W-1:0] cnt_q, cnt_d;         // cycles since reference rise
    logic [PERIOD_W-1:0] period_q, period_d;   // last reference period
    logic                ref_rise;             // reference rising edge

    assign ref_rise = bus_reference_clock & ~bus_q;

    // mode from pins; unlisted codes park the core with no clock
    always_comb begin
        m2_d = ccs_mult2(pll_cfg);
        if (pll_cfg == `CCS_CFG_BYPASS) begin
            mode_d = ccs_pkg::ccs_mode_bypass;
        end else if (m2_d == `CCS_M2_NONE) begin
            mode_d = ccs_pkg::ccs_mode_off;
        end else begin
            mode_d = ccs_pkg::ccs_mode_pll;
        end
        // reference period measured rise to rise
        cnt_d    = ref_rise ? '0 : ((&cnt_q) ? cnt_q : cnt_q + 1'b1);
        period_d = ref_rise ? cnt_q + 1'b1 : period_q;
    end

    // the pins are static, so sampling every cycle is enough
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_q   <= ccs_pkg::ccs_mode_off;
            m2_q     <= `CCS_M2_NONE;
            bus_q    <= 1'b0;
            cnt_q    <= '0;
            period_q <= '0;
        end else begin
            mode_q   <= mode_d;
            m2_q     <= m2_d;
            bus_q    <= bus_reference_clock;
            cnt_q    <= cnt_d;
            period_q <= period_d;
        end
    end

    // ------------------------------------------------------------------------
    // oscillator and core clock
    // ------------------------------------------------------------------------
    logic [PERIOD_W:0]   sum;                  // accumulator plus step
    logic [PERIOD_W-1:0] acc_q, acc_d;         // fractional phase
    logic                vco_q, vco_d;         // oscillator tick
    logic                core_q, core_d;       // core level
    logic                ctick_q, ctick_d;     // core rising pulse
    logic                phase_q, phase_d;     // core half-period tick

    // m2/2 core periods per reference period, so oscillator ticks arrive at
    // m2 per period; rate limit is one tick a cycle, faster settings saturate
    always_comb begin
        sum     = {1'b0, acc_q} + (PERIOD_W+1)'(m2_q);
        acc_d   = '0;
        vco_d   = 1'b0;
        core_d  = 1'b0;
        ctick_d = 1'b0;
        phase_d = 1'b0;
        case (mode_q)
            ccs_pkg::ccs_mode_pll: begin
                if (period_q != '0) begin               // wait for a period
                    if (sum >= {1'b0, period_q}) begin
                        acc_d = PERIOD_W'(sum - {1'b0, period_q});
                        vco_d = 1'b1;
                        if (acc_d >= period_q) begin    // saturated rate
                            acc_d = '0;
                        end
                    end else begin
                        acc_d = PERIOD_W'(sum);
                    end
                end
                // core toggles every oscillator tick: half the rate
                core_d  = vco_q ? ~core_q : core_q;
                ctick_d = vco_q & ~core_q;
                phase_d = vco_q;
            end
            ccs_pkg::ccs_mode_bypass: begin
                // reference is the core clock; edges seen against core_q
                core_d  = bus_reference_clock;
                ctick_d = bus_reference_clock & ~core_q;
                phase_d = bus_reference_clock ^ core_q;
            end
            default: begin
                // everything stays still whatever the reference does
                core_d  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_q   <= '0;
            vco_q   <= 1'b0;
            core_q  <= 1'b0;
            ctick_q <= 1'b0;
            phase_q <= 1'b0;
        end else begin
            acc_q   <= acc_d;
            vco_q   <= vco_d;
            core_q  <= core_d;
            ctick_q <= ctick_d;
            phase_q <= phase_d;
        end
    end

    // ------------------------------------------------------------------------
    // cache clock divider
    // ------------------------------------------------------------------------
    logic cache_div_clk;                       // divided clock before alignment

    ccs_cache_div #(
        .DIV_W      (3)
    ) u_div (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .phase_tick (phase_q),
        .divisor    (cache_clk_divisor),
        .cache_clk  (cache_div_clk)
    );

    // ------------------------------------------------------------------------
    // delay-locked loop
    // ------------------------------------------------------------------------
    logic [DLL_TAPS-1:0] line_q, line_d;       // delay line of divided clock
    logic [TAP_W-1:0]    tap_q, tap_d;         // selected delay
    logic                div_q;                // divided clock one cycle back
    logic                out_q, out_d;         // aligned cache clock
    logic                fbo_q;                // separate sync clock copy
    logic                up_q, up_d;           // last step was upward
    logic                lock_q, lock_d;       // direction has reversed
    logic                slow_q;               // low-speed setting

    // bang-bang phase detector at each internal rising edge: a returned
    // clock already high means its edge came early, so add delay; the loop
    // dithers one tap around the lock point, which is its resolution
    always_comb begin
        line_d = {line_q[DLL_TAPS-2:0], cache_div_clk};
        tap_d  = tap_q;
        up_d   = up_q;
        lock_d = lock_q;
        if (!cache_div_clk && !div_q) begin
            lock_d = lock_q & (cache_clk_divisor != `CCS_DIV_OFF);
        end
        if (cache_div_clk && !div_q) begin
            if (cache_clk_feedback_in) begin
                if (tap_q != TAP_W'(DLL_TAPS-1)) begin
                    tap_d = tap_q + 1'b1;
                end
                lock_d = lock_q | ~up_q;
                up_d   = 1'b1;
            end else begin
                if (tap_q != '0) begin
                    tap_d = tap_q - 1'b1;
                end
                lock_d = lock_q | up_q;
                up_d   = 1'b0;
            end
        end
        out_d = line_q[tap_q];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            line_q <= '0;
            tap_q  <= '0;
            div_q  <= 1'b0;
            out_q  <= 1'b0;
            fbo_q  <= 1'b0;
            up_q   <= 1'b0;
            lock_q <= 1'b0;
            slow_q <= 1'b0;
        end else begin
            line_q <= line_d;
            tap_q  <= tap_d;
            div_q  <= cache_div_clk;
            out_q  <= out_d;
            fbo_q  <= out_d;
            up_q   <= up_d;
            lock_q <= lock_d;
            slow_q <= cache_low_speed_bit;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign core_clk               = core_q;
    assign core_tick              = ctick_q;
    assign vco_tick               = vco_q;
    assign pll_active             = (mode_q == ccs_pkg::ccs_mode_pll);
    assign bypass_active          = (mode_q == ccs_pkg::ccs_mode_bypass);
    assign clocks_off             = (mode_q == ccs_pkg::ccs_mode_off);
    assign cache_clk_out          = out_q;
    assign cache_clk_feedback_out = fbo_q;
    assign dll_locked             = lock_q;
    assign cache_low_speed        = slow_q;

endmodule // ccs_clock_select

//--- tb/ccs_clock_select_props.sv
`timescale 1ns/1ps

module ccs_clock_select_props (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic bus_reference_clock,
    input wire logic cache_low_speed_bit,
    input wire logic core_clk,
    input wire logic core_tick,
    input wire logic vco_tick,
    input wire logic pll_active,
    input wire logic bypass_active,
    input wire logic clocks_off,
    input wire logic cache_clk_out,
    input wire logic cache_clk_feedback_out,
    input wire logic dll_locked,
    input wire logic cache_low_speed
);
    // ------------------------------------------------------------------------
    // one domain, declared once
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------------
    // mode decode and core clock
    // ------------------------------------------------------------------------
    a_mode_one_hot: assert property ($onehot({pll_active, bypass_active, clocks_off}))
        else $error("mode flags not one-hot");
    // second off cycle lets the core register fall
    a_off_all_quiet: assert property (clocks_off && $past(clocks_off) |->
        !core_clk && !core_tick && !vco_tick)
        else $error("off mode not quiet");
    a_bypass_follow: assert property (bypass_active && $past(bypass_active) |->
        core_clk == $past(bus_reference_clock))
        else $error("bypass core not reference");
    a_bypass_no_vco: assert property (bypass_active |-> !vco_tick)
        else $error("oscillator tick in bypass");
    a_vco_pll_only: assert property (vco_tick |-> pll_active)
        else $error("tick outside multiplier mode");
    a_tick_on_rise: assert property (core_tick == (core_clk && !$past(core_clk)))
        else $error("core tick off core rise");
    // each oscillator tick toggles the core
    a_core_after_vco: assert property (pll_active && $past(pll_active) |->
        $changed(core_clk) == $past(vco_tick))
        else $error("core toggle not after tick");

    // ------------------------------------------------------------------------
    // cache clock outputs
    // ------------------------------------------------------------------------
    a_feedback_copy: assert property (cache_clk_feedback_out == cache_clk_out)
        else $error("sync copy differs");
    a_low_speed_delay: assert property ($past(rst_n) |->
        cache_low_speed == $past(cache_low_speed_bit))
        else $error("low-speed not one cycle late");

    c_bypass_tick: cover property (bypass_active && core_tick);
    c_pll_tick: cover property (pll_active && vco_tick);
    c_lock_gained: cover property ($rose(dll_locked));
    c_cache_rise: cover property ($rose(cache_clk_out));
endmodule // ccs_clock_select_props

bind ccs_clock_select ccs_clock_select_props u_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus_reference_clock(bus_reference_clock),
    .cache_low_speed_bit(cache_low_speed_bit), .core_clk(core_clk), .core_tick(core_tick),
    .vco_tick(vco_tick), .pll_active(pll_active), .bypass_active(bypass_active),
    .clocks_off(clocks_off), .cache_clk_out(cache_clk_out),
    .cache_clk_feedback_out(cache_clk_feedback_out), .dll_locked(dll_locked),
    .cache_low_speed(cache_low_speed)
);

//--- tb/ccs_sram_model.sv
`timescale 1ns/1ps

module ccs_sram_model (
    input  wire logic clk_sys,                 // system clock
    input  wire logic rst_n,                   // reset, active low
    input  wire logic slow,                    // long board trace when high
    input  wire logic cache_clk_feedback_out,  // sync clock from the device
    output logic      cache_clk_feedback_in    // sync clock returned
);
    // ------------------------------------------------------------------------
    // trace delay line: the whole way to the srams and back
    // ------------------------------------------------------------------------
    logic [5:0] trace_q;  // delayed copies, newest in bit 0
    logic [5:0] trace_d;  // next delay line state

    // shift the sync clock one stage per cycle
    always_comb begin
        trace_d = {trace_q[4:0], cache_clk_feedback_out};
    end

    // registered trace, cleared on reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            trace_q <= 6'h00;
        end else begin
            trace_q <= trace_d;
        end
    end

    // prompt return after one stage, slow after six
    assign cache_clk_feedback_in = slow ? trace_q[5] : trace_q[0];
endmodule // ccs_sram_model

//--- tb/ccs_clock_select_bench.sv
`timescale 1ns/1ps
`include "ccs_consts.svh"

module ccs_clock_select_bench;
    // ------------------------------------------------------------------------
    // stimulus, outputs and bench state
    // ------------------------------------------------------------------------
    logic        clk_sys = 1'b0, rst_n = 1'b0, bus_reference_clock = 1'b0;
    logic [3:0]  pll_cfg = `CCS_CFG_BYPASS;  // listed code at power-up
    logic [2:0]  div = 3'h1;                 // divisor field
    logic        ls_bit = 1'b0, slow = 1'b0, cc_prev = 1'b0;
    logic        fb_in, core_clk, core_tick, vco_tick, pll_act, byp_act, clk_off;
    logic        cc_out, fb_out, locked, low_spd;
    int          fails = 0, total_checks = 0, cyc = 0, half = 20, ref_cnt = 0;
    int          n_core = 0, n_vco = 0, n_cache = 0, rise_t = 0, per = 0, edge_t = 0;
    int          min_w = 1000;             // shortest cache clock phase seen
    bit          wtrack = 1'b0;            // phase tracking enabled
    logic [31:0] rng = 32'h0000_3032, lrng = 32'h0000_3032;
    logic [3:0]  codes [14] = '{`CCS_CFG_X2_0, `CCS_CFG_X2_5, `CCS_CFG_X3_0, `CCS_CFG_X3_5,
        `CCS_CFG_X4_0, `CCS_CFG_X4_5, `CCS_CFG_X5_0, `CCS_CFG_X5_5, `CCS_CFG_X6_0,
        `CCS_CFG_X6_5, `CCS_CFG_X7_0, `CCS_CFG_X7_5, `CCS_CFG_X8_0, `CCS_CFG_X9_0};

    ccs_clock_select #(.DLL_TAPS(8), .TAP_W(3)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .bus_reference_clock(bus_reference_clock),
        .pll_cfg(pll_cfg), .cache_clk_divisor(div), .cache_low_speed_bit(ls_bit),
        .cache_clk_feedback_in(fb_in), .core_clk(core_clk), .core_tick(core_tick),
        .vco_tick(vco_tick), .pll_active(pll_act), .bypass_active(byp_act),
        .clocks_off(clk_off), .cache_clk_out(cc_out), .cache_clk_feedback_out(fb_out),
        .dll_locked(locked), .cache_low_speed(low_spd));

    ccs_sram_model u_sram (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow),
        .cache_clk_feedback_out(fb_out), .cache_clk_feedback_in(fb_in));

    // ------------------------------------------------------------------------
    // clock, reference and monitors
    // ------------------------------------------------------------------------
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // twice the multiplier, in oscillator ticks per reference period
    function automatic int m2_of(input logic [3:0] c);
        for (int i = 0; i < 14; i++) begin
            if (codes[i] == c) begin
                return (i == 13) ? 18 : 4 + i;
            end
        end
        return 0;
    endfunction

    // reference toggles every half cycles, low-speed bit random per toggle
    always @(posedge clk_sys) begin
        ref_cnt <= (ref_cnt >= half - 1) ? 0 : ref_cnt + 1;
        if (ref_cnt >= half - 1) begin
            bus_reference_clock <= ~bus_reference_clock;
            lrng = xs(lrng);
            ls_bit <= lrng[0];
        end
    end

    // pulse counts, cache period and shortest phase; hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        n_core <= n_core + core_tick;
        n_vco <= n_vco + vco_tick;
        if (cc_out !== cc_prev) begin
            if (wtrack && cyc - edge_t < min_w) begin
                min_w <= cyc - edge_t;
            end
            edge_t <= cyc;
            if (cc_out) begin
                n_cache <= n_cache + 1;
                per <= cyc - rise_t;
                rise_t <= cyc;
            end
        end
        cc_prev <= cc_out;
        if (cyc == 60000) begin
            fails++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // pins are static, so they only change under reset
    task automatic restart(input logic [3:0] cfg, input int h);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        pll_cfg <= cfg;
        half <= h;
        tick(6);
        rst_n <= 1'b1;
    endtask

    task automatic window(input int n, output int c, output int v, output int r);
        int c0, v0, r0;
        @(posedge clk_sys);
        c0 = n_core;
        v0 = n_vco;
        r0 = n_cache;
        tick(n);
        c = n_core - c0;
        v = n_vco - v0;
        r = n_cache - r0;
    endtask

    task automatic cmp_int(input string what, input int exp, input int got, input int tol);
        total_checks++;
        if (got < exp - tol || got > exp + tol) begin
            fails++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        int c, v, r, h;
        logic b;
        tick(6);
        rst_n <= 1'b1;
        rng = xs(rng);
        h = 20 + int'(rng[2:0]);
        restart(`CCS_CFG_BYPASS, h);
        tick(4 * h);
        cmp_bit("bypass flag", 1'b1, byp_act);
        window(8 * h, c, v, r);
        cmp_int("bypass core ticks", 4, c, 1);
        cmp_int("bypass vco ticks", 0, v, 0);
        wtrack = 1'b1;
        // ascending divisors, then a long-to-short jump as the corner case
        for (int k = 1; k <= 8; k++) begin
            div <= (k == 8) ? 3'h1 : 3'(k);
            tick((k == 8) ? 14 * h : 3 * (k + 1) * h);
            cmp_int("cache period", ((k == 8) ? 2 : k + 1) * h, per, 1);
        end
        wtrack = 1'b0;
        cmp_int("shortest cache phase", h, min_w, 1);
        $display("test bypass divisors done");
        for (int i = 0; i < 14; i++) begin
            rng = xs(rng);
            h = 20 + int'(rng[2:0]);
            restart(codes[i], h);
            tick(6 * h);
            cmp_bit("pll flag", 1'b1, pll_act);
            window(8 * h, c, v, r);
            cmp_int("vco ticks", 4 * m2_of(codes[i]), v, 1);
            cmp_int("core ticks", 2 * m2_of(codes[i]), c, 1);
        end
        $display("test multipliers done");
        for (int s = 0; s < 2; s++) begin
            slow <= s[0];
            restart(`CCS_CFG_X9_0, h);
            for (int m = 0; m < 3000 && locked !== 1'b1; m++) begin
                tick(1);
            end
            cmp_bit("delay loop lock", 1'b1, locked);
            div <= `CCS_DIV_OFF;
            tick(200);
            window(200, c, v, r);
            cmp_int("stopped cache rises", 0, r, 0);
            cmp_bit("lock after stop", 1'b0, locked);
            div <= 3'h1;
        end
        $display("test delay loop done");
        restart(`CCS_CFG_OFF, h);
        tick(4 * h);
        cmp_bit("off flag", 1'b1, clk_off);
        window(8 * h, c, v, r);
        cmp_int("off core ticks", 0, c, 0);
        cmp_int("off cache rises", 0, r + v, 0);
        @(posedge clk_sys);
        #1 b = ls_bit;
        @(posedge clk_sys);
        #1 cmp_bit("low speed", b, low_spd);
        $display("test off and low speed done");
        stop_test();
    end
endmodule // ccs_clock_select_bench
